/* File: hw/sbm_regs.vh */
// register offsets, field positions, reset values and timing for the serial byte master
`ifndef SBM_REGS_VH
`define SBM_REGS_VH

// ==========================================================
// register offsets (byte addresses of the register port)
`define SBM_OFS_BYTE_VALUE 8'hB0
`define SBM_OFS_BYTE_OFFSET 8'hB1
`define SBM_OFS_DEVICE_SELECT 8'hB2
`define SBM_OFS_CTRL_STATUS 8'hB3

// ==========================================================
// field positions
`define SBM_DIR_BIT 0
`define SBM_ADDR_MSB 7
`define SBM_ADDR_LSB 1
`define SBM_CS_SHORT_PROT 7
`define SBM_CS_BUSY 5
`define SBM_CS_FAST_TEST 2
`define SBM_CS_REQ_ERR 1

// ==========================================================
// reset values
`define SBM_RST_BYTE 8'h00

// ==========================================================
// timing: serial clock period in ns, quarter periods in clk cycles
`define SBM_CLK_PERIOD_NS 25
`define SBM_SCL_NORMAL_NS 10000
`define SBM_SCL_TEST_NS 1000
// period / 4 / clock period, sized to the divider width
`define SBM_QTR_NORMAL_CYC 8'h64
`define SBM_QTR_TEST_CYC 8'h0A

`endif

/* File: hw/sbm_tick_gen.v */
// quarter-bit enable divider for the serial clock
`include "sbm_regs.vh"

module sbm_tick_gen #(
    parameter CNT_W = 8,
    parameter [CNT_W-1:0] QTR_NORMAL = `SBM_QTR_NORMAL_CYC,
    parameter [CNT_W-1:0] QTR_TEST = `SBM_QTR_TEST_CYC
) (
    input wire clk,
    input wire rst_b,
    input wire run,
    input wire fastTest,
    output reg tick
);

    reg [CNT_W-1:0] count;
    wire [CNT_W-1:0] limit;

    // ==========================================================
    // divider
    // normal or test rate
    assign limit = fastTest ? QTR_TEST : QTR_NORMAL;

    always @(posedge clk) begin
        if (!rst_b || !run) begin
            count <= {CNT_W{1'b0}};
            tick <= 1'b0;
        end else if (count >= limit - 1'b1) begin
            count <= {CNT_W{1'b0}};
            tick <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule

/* File: hw/sbm_master.v */
// software-driven two-wire byte read/write master with its byte register port
`include "sbm_regs.vh"

module sbm_master (
    input wire clk,
    input wire rst_b,
    input wire busResetPin_b,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdData,
    input wire sclIn,
    output wire sclOut,
    output reg sclOe,
    input wire sdaIn,
    output wire sdaOut,
    output reg sdaOe
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_START = 2'b01;
    localparam [1:0] ST_BIT = 2'b10;
    localparam [1:0] ST_STOP = 2'b11;

    localparam [2:0] STEP_ADDR = 3'b000;
    localparam [2:0] STEP_OFFSET = 3'b001;
    localparam [2:0] STEP_DATA = 3'b010;
    localparam [2:0] STEP_RADDR = 3'b011;
    localparam [2:0] STEP_READ = 3'b100;

    reg [7:0] byteValue;
    reg [7:0] byteOffset;
    reg [7:0] deviceSelect;
    reg shortProt;
    reg fastTest;
    reg busy;
    reg reqErr;

    reg [1:0] state;
    reg [1:0] phase;
    reg [2:0] step;
    reg [3:0] bitCnt;
    reg [7:0] shiftReg;
    reg [7:0] rxReg;
    reg ackBad;

    reg sclMeta, sclSync;
    reg sdaMeta, sdaSync;
    reg brMeta, brSync_b;

    wire tick;
    wire advance;
    wire isRead;
    wire dirRead;
    wire launch;
    reg [2:0] next_step;
    reg restartNext;

    // open drain: lines are only ever pulled low
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;

    // ==========================================================
    // pin synchronisers
    always @(posedge clk) begin
        if (!rst_b) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            brMeta <= 1'b1;
            brSync_b <= 1'b1;
        end else begin
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            brMeta <= busResetPin_b;
            brSync_b <= brMeta;
        end
    end

    // ==========================================================
    // quarter-bit timing
    sbm_tick_gen sbm_tick_gen_inst (
        .clk(clk),
        .rst_b(rst_b),
        .run(busy),
        .fastTest(fastTest),
        .tick(tick)
    );

    // a target holding scl low stretches the high phase
    assign advance = tick && (phase != 2'd2 || sclSync || state == ST_IDLE);
    assign isRead = (step == STEP_READ);
    assign dirRead = deviceSelect[`SBM_DIR_BIT];
    assign launch = regWr && !busy && regAddr == `SBM_OFS_DEVICE_SELECT;

    // ==========================================================
    // byte selection
    function [7:0] byte_for;
        input [2:0] stp;
        input [7:0] sel;
        input [7:0] ofs;
        input [7:0] val;
        input shortMode;
        begin
            if (stp == STEP_ADDR) begin
                byte_for = {sel[`SBM_ADDR_MSB:`SBM_ADDR_LSB], shortMode & sel[`SBM_DIR_BIT]};
            end else if (stp == STEP_OFFSET) begin
                byte_for = ofs;
            end else if (stp == STEP_DATA) begin
                byte_for = val;
            end else if (stp == STEP_RADDR) begin
                byte_for = {sel[`SBM_ADDR_MSB:`SBM_ADDR_LSB], 1'b1};
            end else begin
                byte_for = 8'hFF;
            end
        end
    endfunction

    // short protocol skips offset; combined read format
    always @* begin
        next_step = STEP_READ;
        restartNext = 1'b0;
        case (step)
            STEP_ADDR: begin
                if (shortProt) begin
                    next_step = dirRead ? STEP_READ : STEP_DATA;
                end else begin
                    next_step = STEP_OFFSET;
                end
            end
            STEP_OFFSET: begin
                if (dirRead) begin
                    next_step = STEP_RADDR;
                    restartNext = 1'b1;
                end else begin
                    next_step = STEP_DATA;
                end
            end
            default: begin
                next_step = STEP_READ;
            end
        endcase
    end

    // ==========================================================
    // registers and transfer sequencer
    always @(posedge clk) begin
        if (!rst_b) begin
            byteValue <= `SBM_RST_BYTE;
            byteOffset <= `SBM_RST_BYTE;
            deviceSelect <= `SBM_RST_BYTE;
            shortProt <= 1'b0;
            fastTest <= 1'b0;
            busy <= 1'b0;
            reqErr <= 1'b0;
            regRdData <= 8'h00;
            state <= ST_IDLE;
            phase <= 2'd0;
            step <= STEP_ADDR;
            bitCnt <= 4'd0;
            shiftReg <= 8'h00;
            rxReg <= 8'h00;
            ackBad <= 1'b0;
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            if (regRd) begin
                if (regAddr == `SBM_OFS_BYTE_VALUE) begin
                    regRdData <= byteValue;
                end else if (regAddr == `SBM_OFS_BYTE_OFFSET) begin
                    regRdData <= byteOffset;
                end else if (regAddr == `SBM_OFS_DEVICE_SELECT) begin
                    regRdData <= deviceSelect;
                end else if (regAddr == `SBM_OFS_CTRL_STATUS) begin
                    regRdData <= {shortProt, 1'b0, busy, 2'b00, fastTest, reqErr, 1'b0};
                end else begin
                    regRdData <= 8'h00;
                end
            end
            // writes to the transfer fields are ignored while busy
            if (regWr && !busy && regAddr == `SBM_OFS_BYTE_VALUE) begin
                byteValue <= regWrData;
            end
            if (regWr && !busy && regAddr == `SBM_OFS_BYTE_OFFSET) begin
                byteOffset <= regWrData;
            end
            if (regWr && regAddr == `SBM_OFS_CTRL_STATUS) begin
                shortProt <= regWrData[`SBM_CS_SHORT_PROT];
                fastTest <= regWrData[`SBM_CS_FAST_TEST];
                // write one clears; a later set below wins
                if (regWrData[`SBM_CS_REQ_ERR]) begin
                    reqErr <= 1'b0;
                end
            end
            if (!brSync_b) begin
                // bus reset aborts the access but keeps the fields
                state <= ST_IDLE;
                busy <= 1'b0;
                sclOe <= 1'b0;
                sdaOe <= 1'b0;
            end else if (launch) begin
                // target write launches and sets busy
                deviceSelect <= regWrData;
                busy <= 1'b1;
                state <= ST_START;
                phase <= 2'd0;
                step <= STEP_ADDR;
            end else if (advance) begin
                phase <= phase + 2'd1;
                case (state)
                    ST_START: begin
                        if (phase == 2'd0) begin
                            sdaOe <= 1'b0;
                        end else if (phase == 2'd1) begin
                            sclOe <= 1'b0;
                        end else if (phase == 2'd2) begin
                            sdaOe <= 1'b1;
                        end else begin
                            sclOe <= 1'b1;
                            state <= ST_BIT;
                            bitCnt <= 4'd0;
                            shiftReg <= byte_for(step, deviceSelect, byteOffset, byteValue, shortProt);
                        end
                    end
                    ST_BIT: begin
                        if (phase == 2'd0) begin
                            // acknowledge slot always released: ack in, or nack after read
                            sdaOe <= (bitCnt < 4'd8) && !isRead && !shiftReg[7];
                        end else if (phase == 2'd1) begin
                            sclOe <= 1'b0;
                        end else if (phase == 2'd2) begin
                            if (bitCnt < 4'd8) begin
                                rxReg <= {rxReg[6:0], sdaSync};
                            end else begin
                                ackBad <= !isRead && sdaSync;
                            end
                        end else begin
                            sclOe <= 1'b1;
                            if (bitCnt < 4'd8) begin
                                shiftReg <= {shiftReg[6:0], 1'b0};
                                bitCnt <= bitCnt + 4'd1;
                            end else if (ackBad) begin
                                reqErr <= 1'b1;
                                state <= ST_STOP;
                            end else if (step == STEP_READ) begin
                                byteValue <= rxReg;
                                state <= ST_STOP;
                            end else if (step == STEP_DATA) begin
                                state <= ST_STOP;
                            end else if (restartNext) begin
                                step <= next_step;
                                state <= ST_START;
                            end else begin
                                step <= next_step;
                                bitCnt <= 4'd0;
                                shiftReg <= byte_for(next_step, deviceSelect, byteOffset, byteValue, shortProt);
                            end
                        end
                    end
                    ST_STOP: begin
                        if (phase == 2'd0) begin
                            sdaOe <= 1'b1;
                        end else if (phase == 2'd1) begin
                            sclOe <= 1'b0;
                        end else if (phase == 2'd2) begin
                            sdaOe <= 1'b0;
                        end else begin
                            // done: busy clears, read data valid
                            busy <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                    default: begin
                        phase <= 2'd0;
                    end
                endcase
            end
        end
    end

endmodule

/* File: testbench/sbm_master_props.sv */
// port checker for the serial byte master
module sbm_master_props (
    input wire clk,
    input wire rst_b,
    input wire busResetPin_b,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdData,
    input wire sclOe,
    input wire sdaOe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================
    // register port
    property p_rst;
        $rose(rst_b) |-> !regRdData && !sclOe && !sdaOe;
    endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_busy;
        regWr && regAddr == 8'hB2 && busResetPin_b ##2 regRd && regAddr == 8'hB3 |=> regRdData[5];
    endproperty
    a_busy: assert property (p_busy) else $error("busy not set");
    property p_ctrl;
        regWr && regAddr == 8'hB3 ##2 regRd && regAddr == 8'hB3
            |=> regRdData[7] == $past(regWrData[7], 3) && regRdData[2] == $past(regWrData[2], 3);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control bits lost");
    property p_rsvd;
        regRd && regAddr == 8'hB3 |=> regRdData[6] == 1'b0 && regRdData[4:3] == 2'b00 && !regRdData[0];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("unused bits set");
    property p_unmap;
        regRd && (regAddr < 8'hB0 || regAddr > 8'hB3) |=> regRdData == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold;
        !regRd |=> $stable(regRdData);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    // ==========================
    // serial lines
    // even the fast test rate leaves twenty cycles between clock edges
    property p_gap;
        $changed(sclOe) && busResetPin_b |=> ($stable(sclOe) || !busResetPin_b) [*8];
    endproperty
    a_gap: assert property (p_gap) else $error("serial clock too fast");
    property p_busrst;
        $fell(busResetPin_b) |-> ##[1:4] (!sclOe && !sdaOe);
    endproperty
    a_busrst: assert property (p_busrst) else $error("lines not freed");
    c_launch: cover property (regWr && regAddr == 8'hB2);
    c_err: cover property (regRd && regAddr == 8'hB3 ##1 regRdData[1]);
    c_busrst: cover property ($fell(busResetPin_b));
endmodule

bind sbm_master sbm_master_props sbm_master_props_inst (
    .clk(clk), .rst_b(rst_b), .busResetPin_b(busResetPin_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .sclOe(sclOe), .sdaOe(sdaOe));

/* File: testbench/sbm_eeprom_model.sv */
// two-wire byte device model with a 256-byte store
module sbm_eeprom_model #(
    parameter [6:0] DEV_ADDR = 7'h50
) (
    input wire scl,
    input wire sda,
    input wire shortMode,
    output reg sdaPull
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [7:0] mem [0:255];
    reg [7:0] sr;
    reg [7:0] ptr = 8'h00;
    reg active = 0;
    reg rdMode = 0;
    reg ackOk = 0;
    integer bitCnt = 0;
    integer byteCnt = 0;
    initial sdaPull = 0;
    // ==========================
    // framing, seen with the clock high
    always @(negedge sda) if (scl) begin
        active = 1;
        bitCnt = 0;
        byteCnt = 0;
        rdMode = 0;
    end
    always @(posedge sda) if (scl) active = 0;
    always @(posedge scl) if (active) begin
        if (bitCnt < 8) sr = {sr[6:0], sda};
        bitCnt = bitCnt + 1;
    end
    always @(negedge scl) if (active) begin
        sdaPull = 0;
        if (bitCnt == 9) begin
            bitCnt = 0;
            byteCnt = byteCnt + 1;
        end else if (bitCnt == 8 && !(rdMode && byteCnt > 0)) begin
            if (byteCnt == 0) begin
                ackOk = sr[7:1] == DEV_ADDR;
                rdMode = sr[0];
            end else if (byteCnt == 1 && !shortMode) ptr = sr;
            else if (ackOk) mem[ptr] = sr;
            sdaPull = ackOk;
        end
        // only one byte is offered; later bits must not block the stop
        if (bitCnt < 8 && rdMode && byteCnt == 1 && ackOk) sdaPull = !mem[ptr][7 - bitCnt];
    end
endmodule

/* File: testbench/tb_sbm_master.sv */
// self-checking bench for the serial byte master
module tb_sbm_master;
    timeunit 1ns;
    timeprecision 100ps;
    reg clk = 0;
    reg rst_b = 0;
    reg busResetPin_b = 1;
    reg [7:0] regAddr = 8'h00;
    reg [7:0] regWrData = 8'h00;
    reg regWr = 0;
    reg regRd = 0;
    reg shortMode = 0;
    wire [7:0] regRdData;
    wire sclOe, sdaOe, sdaPull;
    wire sclLvl, sdaLvl;
    // pulled-up wires: an enabled driver shows its output level
    wire sclWire = sclOe ? sclLvl : 1'b1;
    wire sdaWire = (sdaOe ? sdaLvl : 1'b1) && !sdaPull;
    reg [7:0] v;
    reg [23:0] rows [0:4];
    integer mismatches = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    integer t0;
    integer i;
    always #12.5 clk = !clk;
    sbm_master sbm_master_inst (
        .clk(clk), .rst_b(rst_b), .busResetPin_b(busResetPin_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .sclIn(sclWire), .sclOut(sclLvl), .sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(sdaLvl), .sdaOe(sdaOe));
    sbm_eeprom_model #(.DEV_ADDR(7'h50)) sbm_eeprom_model_inst (
        .scl(sclWire), .sda(sdaWire), .shortMode(shortMode), .sdaPull(sdaPull));
    // ==========================
    // tasks
    task chk(input [7:0] seen, input [7:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1;
        @(posedge clk);
        regWr <= 0;
    endtask
    task rd(input [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1;
        @(posedge clk);
        regRd <= 0;
        #1 v = regRdData;
    endtask
    task poll;
        v = 8'h20;
        while (v[5] === 1'b1) rd(8'hB3);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end
    // ==========================
    // sequence
    initial begin
        rows[0] = 24'hB0A5A5;
        rows[1] = 24'hB13C3C;
        rows[2] = 24'hB3FF84;
        rows[3] = 24'hB45500;
        rows[4] = 24'hAF5500;
        repeat (16) @(posedge clk);
        rst_b <= 1;
        for (i = 0; i < 5; i = i + 1) begin
            rd(rows[i][23:16]);
            chk(v, 8'h00);
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chk(v, rows[i][7:0]);
        end
        wr(8'hB3, 8'h00);
        t0 = cyc;
        wr(8'hB2, 8'hA0);
        poll;
        chk(v, 8'h00);
        chk(sbm_eeprom_model_inst.mem[8'h3C], 8'hA5);
        // start, 27 bits and stop: 29 bit times of 400 cycles at 100 kHz
        chk({7'h00, cyc - t0 > 11400 && cyc - t0 < 12000}, 8'h01);
        sbm_eeprom_model_inst.mem[8'h07] = 8'h5A;
        wr(8'hB1, 8'h07);
        wr(8'hB2, 8'hA1);
        poll;
        rd(8'hB0);
        chk(v, 8'h5A);
        rd(8'hB2);
        chk(v, 8'hA1);
        shortMode <= 1;
        wr(8'hB3, 8'h84);
        wr(8'hB0, 8'hC3);
        t0 = cyc;
        wr(8'hB2, 8'hA0);
        poll;
        chk({7'h00, cyc - t0 < 2000}, 8'h01);
        chk(sbm_eeprom_model_inst.mem[8'h07], 8'hC3);
        sbm_eeprom_model_inst.mem[8'h07] = 8'h96;
        wr(8'hB2, 8'hA1);
        poll;
        rd(8'hB0);
        chk(v, 8'h96);
        // absent device gives a missing acknowledge
        wr(8'hB2, 8'hA2);
        poll;
        chk(v, 8'h86);
        wr(8'hB3, 8'h86);
        rd(8'hB3);
        chk(v, 8'h84);
        shortMode <= 0;
        wr(8'hB3, 8'h00);
        wr(8'hB2, 8'hA0);
        // offset write while busy must be refused
        wr(8'hB1, 8'hEE);
        repeat (298) @(posedge clk);
        busResetPin_b <= 0;
        repeat (4) @(posedge clk);
        busResetPin_b <= 1;
        repeat (4) @(posedge clk);
        rd(8'hB3);
        chk(v, 8'h00);
        rd(8'hB2);
        chk(v, 8'hA0);
        rd(8'hB1);
        chk(v, 8'h07);
        rd(8'hB0);
        chk(v, 8'h96);
        close_out;
    end
endmodule
